// ### rtl/lvm_pkg.sv
// Purpose: shared constants and types for the supply low-voltage monitor
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   register indexes double as port addresses (one register per address)

package lvm_pkg;

	// ****************************************************************
	// register port
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} lvm_bus_req_s;

	// register addresses
	localparam logic [ADDR_W-1:0] LOW_VOLTAGE_MONITOR_CONTROL_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] MONITOR_IRQ_STATUS_ADDR          = 4'h1;

	// control register field positions
	localparam int CTRL_DETECT_BIT = 5;
	localparam int CTRL_ENABLE_BIT = 4;
	localparam int CTRL_SEL_HI     = 2;
	localparam int CTRL_SEL_LO     = 0;
	// status register field position
	localparam int STAT_IRQ_BIT    = 0;

	// reset values
	localparam logic       ENABLE_RST = 1'b0;
	localparam logic [2:0] SEL_RST    = 3'h0;
	localparam logic       DETECT_RST = 1'b0;
	localparam logic       IRQ_RST    = 1'b0;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS          = 10;
	// detection delay before the request flag may rise
	localparam int MONITOR_IRQ_DELAY_NS   = 100;
	localparam int MONITOR_IRQ_DELAY_CYC  =
		(MONITOR_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// threshold levels in millivolts
	// ****************************************************************
	localparam int SUPPLY_W = 13;

	function automatic logic [SUPPLY_W-1:0] lvm_threshold_mv(input logic [2:0] sel);
		logic [SUPPLY_W-1:0] mv;
		mv = 13'h7D0;
		case (sel)
			3'h0: mv = 13'h7D0; // 2.0 V
			3'h1: mv = 13'h898; // 2.2 V
			3'h2: mv = 13'h960; // 2.4 V
			3'h3: mv = 13'hA8C; // 2.7 V
			3'h4: mv = 13'hBB8; // 3.0 V
			3'h5: mv = 13'hCE4; // 3.3 V
			3'h6: mv = 13'hE10; // 3.6 V
			default: mv = 13'hFA0; // 4.0 V
		endcase
		return mv;
	endfunction

endpackage

// ### rtl/lvm_monitor.sv
// Purpose: control, detect flag and delayed request flag of the supply monitor
// Assumes: supply_mv_i is a digitised supply reading from the analog front end
// Notes:   one clock, synchronous active-low reset, no wait states on the port
//
// Notes on behaviour
// - unused control bits 7, 6, 3 read zero
// - control bit 5 is read-only detect flag
// - control bit 4 switches the detector on/off
// - bits 2..0 pick one of eight levels
// - enabled: flag high while supply below threshold
// - flag follows comparator, may toggle repeatedly
// - request flag rises only after detection delay
// - set request wakes core; software may preset

`timescale 1ns/1ns

module lvm_monitor
	import lvm_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire lvm_bus_req_s        bus_i,
	output logic      [DATA_W-1:0]   bus_rdata_o,
	input  wire logic [SUPPLY_W-1:0] supply_mv_i,
	output logic                     monitor_power_on_o,
	output logic                     supply_low_detect_o,
	output logic                     irq_request_o,
	output logic                     wake_o
);

	localparam logic [CNT_W-1:0] IRQ_LAST = CNT_W'(MONITOR_IRQ_DELAY_CYC - 1);

	// ****************************************************************
	// state
	// ****************************************************************
	logic                supply_low_detect_flag;
	logic                supply_monitor_enable;
	logic [2:0]          supply_threshold_select;
	logic                supply_monitor_irq_request;
	logic [CNT_W-1:0]    irq_cnt;
	logic [SUPPLY_W-1:0] supply_meta;
	logic [SUPPLY_W-1:0] supply_sync;
	logic [DATA_W-1:0]   rdata;

	logic                next_detect;
	logic                next_enable;
	logic [2:0]          next_sel;
	logic                next_irq;
	logic [CNT_W-1:0]    next_irq_cnt;
	logic [DATA_W-1:0]   next_rdata;

	logic                wr_ctrl;
	logic                wr_stat;
	logic                below;
	logic                irq_set;

	// decoded write strobes
	assign wr_ctrl = bus_i.wr && (bus_i.addr == LOW_VOLTAGE_MONITOR_CONTROL_ADDR);
	assign wr_stat = bus_i.wr && (bus_i.addr == MONITOR_IRQ_STATUS_ADDR);

	// ****************************************************************
	// supply synchroniser
	// ****************************************************************
	// the reading comes from the analog domain, so two stages before use
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			supply_meta <= '0;
			supply_sync <= '0;
		end else begin
			supply_meta <= supply_mv_i;
			supply_sync <= supply_meta;
		end
	end

	// ****************************************************************
	// control and comparator
	// ****************************************************************
	// comparator against the selected level, always evaluated; the enable masks its result so the flag stays low when disabled
	always_comb begin
		below       = supply_sync < lvm_threshold_mv(supply_threshold_select);
		next_enable = supply_monitor_enable;
		next_sel    = supply_threshold_select;
		if (wr_ctrl) begin
			next_enable = bus_i.wdata[CTRL_ENABLE_BIT];
			next_sel    = bus_i.wdata[CTRL_SEL_HI:CTRL_SEL_LO];
		end
		// no hysteresis: near the level the flag may chatter
		next_detect = supply_monitor_enable && below;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			supply_monitor_enable   <= ENABLE_RST;
			supply_threshold_select <= SEL_RST;
			supply_low_detect_flag  <= DETECT_RST;
		end else begin
			supply_monitor_enable   <= next_enable;
			supply_threshold_select <= next_sel;
			supply_low_detect_flag  <= next_detect;
		end
	end

	// ****************************************************************
	// delayed request flag
	// ****************************************************************
	// the run counter restarts on any drop so short dips never raise a request
	always_comb begin
		irq_set      = supply_low_detect_flag && (irq_cnt >= IRQ_LAST);
		next_irq_cnt = '0;
		if (supply_low_detect_flag) begin
			next_irq_cnt = (irq_cnt >= IRQ_LAST) ? irq_cnt : irq_cnt + 1'b1;
		end
		next_irq = supply_monitor_irq_request;
		if (wr_stat) begin
			next_irq = bus_i.wdata[STAT_IRQ_BIT];
		end
		// hardware set wins over a software clear in the same cycle
		if (irq_set) begin
			next_irq = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_cnt                    <= '0;
			supply_monitor_irq_request <= IRQ_RST;
		end else begin
			irq_cnt                    <= next_irq_cnt;
			supply_monitor_irq_request <= next_irq;
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	// data only in the cycle after the strobe; unmapped addresses read zero
	always_comb begin
		next_rdata = '0;
		if (bus_i.rd) begin
			if (bus_i.addr == LOW_VOLTAGE_MONITOR_CONTROL_ADDR) begin
				next_rdata[CTRL_DETECT_BIT]         = supply_low_detect_flag;
				next_rdata[CTRL_ENABLE_BIT]         = supply_monitor_enable;
				next_rdata[CTRL_SEL_HI:CTRL_SEL_LO] = supply_threshold_select;
			end else if (bus_i.addr == MONITOR_IRQ_STATUS_ADDR) begin
				next_rdata[STAT_IRQ_BIT] = supply_monitor_irq_request;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	// outputs
	assign bus_rdata_o         = rdata;
	assign monitor_power_on_o  = supply_monitor_enable;
	assign supply_low_detect_o = supply_low_detect_flag;
	assign irq_request_o       = supply_monitor_irq_request;
	// wake follows the flag, so a software preset of the flag also raises wake
	assign wake_o              = supply_monitor_irq_request;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_ctrl_read;
		bus_i.rd && (bus_i.addr == LOW_VOLTAGE_MONITOR_CONTROL_ADDR);
	endsequence

	sequence s_irq_kept;
		supply_monitor_irq_request && !(wr_stat && !bus_i.wdata[STAT_IRQ_BIT]);
	endsequence

	sequence s_short_dip;
		!supply_monitor_irq_request && !wr_stat && $rose(supply_low_detect_flag)
			##1 !supply_low_detect_flag && !wr_stat;
	endsequence

	AST_RSVD_ZERO: assert property (s_ctrl_read |=>
		bus_rdata_o[7:6] == 2'h0 && bus_rdata_o[3] == 1'b0)
		else $error("reserved control bits read nonzero");

	AST_DETECT_READ: assert property (s_ctrl_read |=>
		bus_rdata_o[CTRL_DETECT_BIT] == $past(supply_low_detect_flag))
		else $error("detect bit read wrong");

	AST_ENABLE_WRITE: assert property (wr_ctrl |=>
		supply_monitor_enable == $past(bus_i.wdata[CTRL_ENABLE_BIT])
		&& supply_threshold_select == $past(bus_i.wdata[2:0]))
		else $error("control write not taken");

	AST_OFF_QUIET: assert property (!supply_monitor_enable |=>
		!supply_low_detect_flag)
		else $error("detect flag high while disabled");

	// code 4 is 3.0 V: one millivolt below flags, the level itself does not
	AST_LEVEL_TABLE: assert property (
		(supply_monitor_enable && supply_threshold_select == 3'h4)
		|=> supply_low_detect_flag == ($past(supply_sync) < 13'hBB8))
		else $error("threshold decode wrong");

	AST_DETECT_FOLLOWS: assert property (
		(supply_monitor_enable && below) |=> supply_low_detect_flag)
		else $error("low supply not flagged");

	AST_DETECT_CLEARS: assert property (
		!below |=> !supply_low_detect_flag)
		else $error("flag held above threshold");

	AST_IRQ_EARLY: assert property (
		(!supply_monitor_irq_request && !wr_stat && irq_cnt < IRQ_LAST)
		|=> !supply_monitor_irq_request)
		else $error("request raised before delay");

	AST_IRQ_SHORT: assert property (s_short_dip |=> !supply_monitor_irq_request)
		else $error("short dip raised request");

	AST_IRQ_RAISE: assert property (
		(supply_low_detect_flag && irq_cnt >= IRQ_LAST) |=> supply_monitor_irq_request)
		else $error("request not raised after delay");

	AST_IRQ_STICKY: assert property (s_irq_kept |=> supply_monitor_irq_request)
		else $error("request dropped without clear");

	AST_WAKE: assert property ($rose(supply_monitor_irq_request) |-> wake_o)
		else $error("no wake on request");

	AST_RESET_CLEAR: assert property (@(posedge clk_i) disable iff (1'b0)
		!rst_n_i |=> !supply_monitor_enable && supply_threshold_select == 3'h0
		&& !supply_low_detect_flag && !supply_monitor_irq_request)
		else $error("reset did not clear control");

endmodule

// ### verification/lvm_monitor_tb.sv
// Purpose: self-checking bench for the supply monitor control block
// Assumes: lvm_pkg constants, default counter width, digitised supply word
// Notes:   a cycle model runs beside the design and is compared every cycle outside reset
`timescale 1ns/1ns
module lvm_monitor_tb;
	import lvm_pkg::*;
	// ****************************************************************
	// signals and model state
	// ****************************************************************
	logic                clk_i;
	logic                rst_n_i;
	lvm_bus_req_s        bus;
	logic [DATA_W-1:0]   rdata;
	logic [SUPPLY_W-1:0] sup;
	logic                pwr;
	logic                det;
	logic                irq;
	logic                wake;
	int                  err_count = 0;
	int                  comparisons = 0;
	int                  lvl[8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
	logic [31:0]         seed = 32'hC166;
	int                  s1;
	int                  s2;
	int                  m_cnt;
	logic                m_en;
	logic                m_det;
	logic                m_irq;
	logic [2:0]          m_sel;
	logic [7:0]          m_rd;

	lvm_monitor DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .bus_rdata_o(rdata),
		.supply_mv_i(sup), .monitor_power_on_o(pwr), .supply_low_detect_o(det),
		.irq_request_o(irq), .wake_o(wake));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one strobe cycle then an idle cycle, so no signal is driven twice in one step
	task automatic bus_op(input logic w, input logic [3:0] a, input logic [7:0] d);
		bus <= '{a, d, w, !w};
		@(posedge clk_i);
		bus <= '0;
		@(posedge clk_i);
	endtask

	// cycle model: two sync stages, registered compare, delay counter, sticky flag
	always @(posedge clk_i) begin
		if (rst_n_i !== 1'b1) begin
			s1 <= 0;
			s2 <= 0;
			m_cnt <= 0;
			m_en <= 1'b0;
			m_det <= 1'b0;
			m_irq <= 1'b0;
			m_sel <= 3'h0;
			m_rd <= 8'h00;
		end else begin
			s1 <= sup;
			s2 <= s1;
			m_det <= m_en && (s2 < lvl[m_sel]);
			m_cnt <= m_det ? ((m_cnt < 255) ? m_cnt + 1 : m_cnt) : 0;
			m_rd <= 8'h00;
			if (bus.rd && bus.addr == LOW_VOLTAGE_MONITOR_CONTROL_ADDR)
				m_rd <= {2'b00, m_det, m_en, 1'b0, m_sel};
			if (bus.rd && bus.addr == MONITOR_IRQ_STATUS_ADDR)
				m_rd <= {7'h00, m_irq};
			if (bus.wr && bus.addr == LOW_VOLTAGE_MONITOR_CONTROL_ADDR) begin
				m_en <= bus.wdata[4];
				m_sel <= bus.wdata[2:0];
			end
			// hardware set wins over a software clear in the same cycle
			if (m_det && m_cnt >= MONITOR_IRQ_DELAY_CYC - 1)
				m_irq <= 1'b1;
			else if (bus.wr && bus.addr == MONITOR_IRQ_STATUS_ADDR)
				m_irq <= bus.wdata[0];
		end
	end

	// compare on the falling edge, where every registered output has settled
	always @(negedge clk_i) begin
		if (rst_n_i === 1'b1) begin
			check("rdata", rdata, m_rd);
			check("power_on", {7'h00, pwr}, {7'h00, m_en});
			check("detect", {7'h00, det}, {7'h00, m_det});
			check("irq", {7'h00, irq}, {7'h00, m_irq});
			check("wake", {7'h00, wake}, {7'h00, m_irq});
		end
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		int n;
		bus = '0;
		sup = 13'h0FA0;
		rst_n_i = 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		bus_op(1'b0, MONITOR_IRQ_STATUS_ADDR, 8'h00);
		bus_op(1'b0, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'h00);
		// every code with unused and read-only bits set; just below, then at the level
		for (int k = 0; k < 8; k++) begin
			bus_op(1'b1, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'hF8 | 8'(k));
			sup <= SUPPLY_W'(lvl[k] - 1);
			cyc(4); // settle before reading
			bus_op(1'b0, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'h00);
			sup <= SUPPLY_W'(lvl[k]);
			cyc(4);
			bus_op(1'b0, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'h00);
		end
		// switched off: a very low supply must not show
		bus_op(1'b1, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'h07);
		sup <= 13'h0000;
		cyc(20);
		// chatter around 3.0 V, each low spell shorter than the delay, first one a single cycle
		sup <= 13'h0BB8;
		bus_op(1'b1, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'h14);
		cyc(3);
		sup <= 13'h0BB7;
		cyc(1);
		sup <= 13'h0BB8;
		cyc(4);
		repeat (6) begin
			sup <= 13'h0BB7;
			cyc(3);
			sup <= 13'h0BB8;
			cyc(3);
		end
		// a held low supply raises the request within a bounded wait
		sup <= 13'h09C4;
		// look on the falling edge so the flag is settled, then resume on a rising edge
		for (n = 0; n < 30 && irq !== 1'b1; n++)
			@(negedge clk_i);
		check("irq_wait", {7'h00, irq}, 8'h01);
		@(posedge clk_i);
		bus_op(1'b1, MONITOR_IRQ_STATUS_ADDR, 8'h00);
		sup <= 13'h0DAC;
		cyc(6);
		bus_op(1'b1, MONITOR_IRQ_STATUS_ADDR, 8'h00);
		bus_op(1'b0, MONITOR_IRQ_STATUS_ADDR, 8'h00);
		bus_op(1'b1, MONITOR_IRQ_STATUS_ADDR, 8'hFF);
		bus_op(1'b0, MONITOR_IRQ_STATUS_ADDR, 8'h00);
		// unmapped place: writes vanish, reads give zero
		bus_op(1'b1, 4'hF, 8'hFF);
		bus_op(1'b0, 4'hF, 8'h00);
		bus_op(1'b0, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'h00);
		// random supply with occasional random register traffic
		repeat (400) begin
			seed = xs(seed);
			sup <= SUPPLY_W'(1800 + seed % 2400);
			if (seed[20:18] == 3'h0)
				bus_op(seed[21], seed[22] ? MONITOR_IRQ_STATUS_ADDR
					: LOW_VOLTAGE_MONITOR_CONTROL_ADDR, seed[31:24]);
			else
				cyc(1 + 4 * seed[23]);
		end
		// reset in mid-run with the detector on and the request set
		bus_op(1'b1, MONITOR_IRQ_STATUS_ADDR, 8'h01);
		bus_op(1'b1, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'h17);
		rst_n_i <= 1'b0;
		cyc(2);
		rst_n_i <= 1'b1;
		cyc(1);
		bus_op(1'b0, LOW_VOLTAGE_MONITOR_CONTROL_ADDR, 8'h00);
		bus_op(1'b0, MONITOR_IRQ_STATUS_ADDR, 8'h00);
		print_verdict();
	end
endmodule
